// File: verilog/gwk_cfg.svh
// Purpose: Constants for the pin wake and external interrupt block
// Assumes: Included by bare name
// Notes: Byte addresses on a 32-bit Wishbone bus
`ifndef GWK_CFG_SVH
`define GWK_CFG_SVH
// ==========================================
// Register byte addresses
`define GWK_ADR_FLAGS 32'h4000a814
`define GWK_ADR_CFG_A 32'h4000a860
`define GWK_ADR_CFG_B 32'h4000a864
`define GWK_ADR_CFG_C 32'h4000a868
`define GWK_ADR_CFG_D 32'h4000a86c
`define GWK_ADR_WAKE_A 32'h4000bc08
`define GWK_ADR_WAKE_B 32'h4000bc0c
`define GWK_ADR_WAKE_C 32'h4000bc10
`define GWK_ADR_SEL_C 32'h4000bc14
`define GWK_ADR_SEL_D 32'h4000bc18
`define GWK_ADR_FILT 32'h4000bc1c
// ==========================================
// Field positions
`define GWK_CFG_FILT_BIT 8
`define GWK_CFG_MODE_LSB 5
`define GWK_WF_PINS_BIT 0
`define GWK_WF_SERIAL_BIT 1
`define GWK_WF_CHAN_D_BIT 3
`define GWK_FLAG_MASK 4'hd
`define GWK_SERIAL_PIN 5'h0a
// ==========================================
// Reset values and timing
`define GWK_SEL_C_RST 5'h0f
`define GWK_SEL_D_RST 5'h10
`define GWK_FILT_LEN 4
`endif

// File: verilog/gwk_pkg.sv
// Purpose: Types for the pin wake and external interrupt block
// Assumes: Nothing
// Notes: Trigger codes follow the channel configuration field
`default_nettype none
package gwk_pkg;
  typedef enum logic [2:0] {
    GWK_OFF = 3'h0,
    GWK_RISE = 3'h1,
    GWK_FALL = 3'h2,
    GWK_BOTH = 3'h3,
    GWK_HIGH = 3'h4,
    GWK_LOW = 3'h5
  } gwk_mode_t;
endpackage
`default_nettype wire

// File: verilog/gwk_wake_irq.sv
// Purpose: Pin wake monitor and four external interrupt channels
// Assumes: One 100 MHz clock, synchronous reset, classic Wishbone slave
// Notes: Pins pass three flops; one history filter bank serves all users
`include "gwk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module gwk_wake_irq #(
  parameter int FILT_LEN = `GWK_FILT_LEN,
  parameter logic [4:0] CHAN_A_PIN = 5'h08,
  parameter logic [4:0] CHAN_B_PIN = 5'h0e
) (
  // System
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [31:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Pins
  input wire logic [7:0] PORT_A_I,
  input wire logic [7:0] PORT_B_I,
  input wire logic [7:0] PORT_C_I,
  input wire logic SERIAL_WAKE_EN_I,
  // Events
  output logic [3:0] IRQ_O,
  output logic WAKE_O
);

  // Elaboration check: the history shift needs two taps, and long ones only add latency
  if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_bad_filt_len
    $error("FILT_LEN out of range");
  end

  // ==========================================
  // Helpers
  // Legal select codes only; others give no pin
  function automatic logic sel_ok(input logic [4:0] c);
    sel_ok = (c == 5'h04) || (c == 5'h05) || (c == 5'h07) ||
             (c >= 5'h08 && c <= 5'h0c) || (c >= 5'h10 && c <= 5'h17);
  endfunction

  function automatic logic pick(input logic [23:0] v, input logic [4:0] c);
    pick = sel_ok(c) ? v[c] : 1'b0;
  endfunction

  function automatic logic trig(input logic [2:0] m, input logic cur, input logic prv);
    unique case (m)
      gwk_pkg::GWK_RISE: trig = cur & ~prv;
      gwk_pkg::GWK_FALL: trig = ~cur & prv;
      gwk_pkg::GWK_BOTH: trig = cur ^ prv;
      gwk_pkg::GWK_HIGH: trig = cur;
      gwk_pkg::GWK_LOW: trig = ~cur;
      default: trig = 1'b0;
    endcase
  endfunction

  // ==========================================
  // Registers
  logic [3:0] pend_q;
  logic [8:0] cfg_q [4];
  logic [7:0] wen_q [3];
  logic [4:0] sel_c_q;
  logic [4:0] sel_d_q;
  logic [3:0] wf_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic req;
  logic wr;
  logic [31:0] rd;
  logic [31:0] wmask;
  logic [4:0] csel [4];
  logic [3:0] hit;

  assign req = CYC_I & STB_I & ~ack_q;
  // Write lands on the edge where the master sees ack, so a dropped request never writes
  assign wr = CYC_I & STB_I & WE_I & ack_q;
  assign wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

  // ==========================================
  // Input synchronisers and filter bank
  logic [23:0] s1_q, s2_q, s3_q, clean_q, filt_q;
  logic [FILT_LEN-1:0] hist_q [24];

  // Third flop guards against a change seen in one flop only
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      s1_q <= 24'h000000;
      s2_q <= 24'h000000;
      s3_q <= 24'h000000;
      clean_q <= 24'h000000;
    end else begin
      s1_q <= {PORT_C_I, PORT_B_I, PORT_A_I};
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
    end
  end

  // Filtered level moves only after FILT_LEN equal samples; costs latency
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      filt_q <= 24'h000000;
      for (int i = 0; i < 24; i++) begin
        hist_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 24; i++) begin
        hist_q[i] <= {hist_q[i][FILT_LEN-2:0], clean_q[i]};
        if (&hist_q[i]) begin
          filt_q[i] <= 1'b1;
        end else if (~|hist_q[i]) begin
          filt_q[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // Channel inputs and trigger detection
  logic [3:0] chan_in, chan_prv_q;

  always_comb begin
    csel[0] = CHAN_A_PIN;
    csel[1] = CHAN_B_PIN;
    csel[2] = sel_c_q;
    csel[3] = sel_d_q;
    for (int k = 0; k < 4; k++) begin
      // Filter option per channel
      chan_in[k] = cfg_q[k][`GWK_CFG_FILT_BIT] ? pick(filt_q, csel[k]) : pick(clean_q, csel[k]);
      hit[k] = trig(cfg_q[k][7:`GWK_CFG_MODE_LSB], chan_in[k], chan_prv_q[k]);
    end
  end

  // Previous level for edge detection
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      chan_prv_q <= 4'h0;
    end else begin
      chan_prv_q <= chan_in;
    end
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pend_q <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (hit[k]) begin
          pend_q[k] <= 1'b1;
        end else if (wr && ADR_I == `GWK_ADR_FLAGS && SEL_I[0] && DAT_I[k]) begin
          pend_q[k] <= 1'b0;
        end
      end
    end
  end

  assign IRQ_O = pend_q;

  // ==========================================
  // Wake monitor
  logic [23:0] wview, wview_q, wen_all;
  logic ser_v, ser_q, chd_v, chd_q, wake_d, wake_q;

  assign wen_all = {wen_q[2], wen_q[1], wen_q[0]};
  assign wview = wf_q[`GWK_WF_PINS_BIT] ? filt_q : clean_q;
  assign ser_v = wf_q[`GWK_WF_SERIAL_BIT] ? filt_q[`GWK_SERIAL_PIN] : clean_q[`GWK_SERIAL_PIN];
  assign chd_v = wf_q[`GWK_WF_CHAN_D_BIT] ? pick(filt_q, sel_d_q) : pick(clean_q, sel_d_q);
  // Only enabled pins may wake
  assign wake_d = |((wview ^ wview_q) & wen_all) | (SERIAL_WAKE_EN_I & (ser_v ^ ser_q)) |
                  ((cfg_q[3][7:5] != 3'h0) & (chd_v ^ chd_q));

  // One-cycle wake pulse, registered
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wview_q <= 24'h000000;
      ser_q <= 1'b0;
      chd_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wview_q <= wview;
      ser_q <= ser_v;
      chd_q <= chd_v;
      wake_q <= wake_d;
    end
  end

  assign WAKE_O = wake_q;

  // ==========================================
  // Wishbone register file
  always_comb begin
    rd = 32'h00000000;
    unique case (ADR_I)
      `GWK_ADR_FLAGS: rd = {28'h0000000, pend_q & `GWK_FLAG_MASK};
      `GWK_ADR_CFG_A: rd = {23'h000000, cfg_q[0]};
      `GWK_ADR_CFG_B: rd = {23'h000000, cfg_q[1]};
      `GWK_ADR_CFG_C: rd = {23'h000000, cfg_q[2]};
      `GWK_ADR_CFG_D: rd = {23'h000000, cfg_q[3]};
      `GWK_ADR_WAKE_A: rd = {24'h000000, wen_q[0]};
      `GWK_ADR_WAKE_B: rd = {24'h000000, wen_q[1]};
      `GWK_ADR_WAKE_C: rd = {24'h000000, wen_q[2]};
      `GWK_ADR_SEL_C: rd = {27'h0000000, sel_c_q};
      `GWK_ADR_SEL_D: rd = {27'h0000000, sel_d_q};
      `GWK_ADR_FILT: rd = {28'h0000000, wf_q & 4'hb};
      default: rd = 32'h00000000;
    endcase
  end

  // Writes take effect on the edge at which ack is seen high
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int k = 0; k < 4; k++) begin
        cfg_q[k] <= 9'h000;
      end
      for (int p = 0; p < 3; p++) begin
        wen_q[p] <= 8'h00;
      end
      sel_c_q <= `GWK_SEL_C_RST;
      sel_d_q <= `GWK_SEL_D_RST;
      wf_q <= 4'h0;
    end else if (wr) begin
      for (int k = 0; k < 4; k++) begin
        if (ADR_I == `GWK_ADR_CFG_A + 32'(4 * k)) begin
          cfg_q[k] <= (cfg_q[k] & ~wmask[8:0]) | (DAT_I[8:0] & wmask[8:0] & 9'h1e0);
        end
      end
      for (int p = 0; p < 3; p++) begin
        if (ADR_I == `GWK_ADR_WAKE_A + 32'(4 * p) && SEL_I[0]) begin
          wen_q[p] <= DAT_I[7:0];
        end
      end
      if (ADR_I == `GWK_ADR_SEL_C && SEL_I[0]) begin
        sel_c_q <= DAT_I[4:0];
      end
      if (ADR_I == `GWK_ADR_SEL_D && SEL_I[0]) begin
        sel_d_q <= DAT_I[4:0];
      end
      if (ADR_I == `GWK_ADR_FILT && SEL_I[0]) begin
        wf_q <= DAT_I[3:0] & 4'hb;
      end
    end
  end

  // Ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= rd;
      end
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = rdat_q;

  // ==========================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence clr_a_s;
    wr && ADR_I == `GWK_ADR_FLAGS && SEL_I[0] && DAT_I[0] && !hit[0];
  endsequence

  pend_set_a: assert property (hit[0] |=> pend_q[0] && IRQ_O[0])
    else $error("Channel A trigger did not set flag");
  w1c_clear_a: assert property (clr_a_s |=> !pend_q[0])
    else $error("Write one did not clear flag");
  zero_keep_a: assert property (wr && ADR_I == `GWK_ADR_FLAGS && !DAT_I[2] && pend_q[2] |=> pend_q[2])
    else $error("Zero write changed flag");
  mode_off_a: assert property (cfg_q[1][7:5] == 3'h0 |-> !hit[1])
    else $error("Disabled channel triggered");
  rise_hit_a: assert property (cfg_q[0][7:5] == 3'h1 && $rose(chan_in[0]) |-> hit[0])
    else $error("Rising edge missed");
  level_low_a: assert property (cfg_q[2][7:5] == 3'h5 && !chan_in[2] |=> pend_q[2])
    else $error("Low level did not hold flag");
  flag_read_a: assert property (req && !WE_I && ADR_I == `GWK_ADR_FLAGS |=>
    DAT_O[1] == 1'b0 && DAT_O[3] == $past(pend_q[3]))
    else $error("Flag read layout wrong");
  sel_route_a: assert property (sel_d_q == 5'h10 && !cfg_q[3][8] |-> chan_in[3] == clean_q[16])
    else $error("Select code routed wrong pin");
  sel_bad_a: assert property (sel_c_q >= 5'h18 |-> !chan_in[2])
    else $error("Reserved select gave a pin");
  filt_use_a: assert property (cfg_q[0][8] && sel_ok(CHAN_A_PIN) |-> chan_in[0] == filt_q[CHAN_A_PIN])
    else $error("Channel filter bypassed");
  wake_gate_a: assert property (wen_all == 24'h000000 && !SERIAL_WAKE_EN_I && cfg_q[3][7:5] == 3'h0 |=> !WAKE_O)
    else $error("Wake from unmonitored pin");
  wake_pin_a: assert property (wen_q[0][0] && !wf_q[0] && $changed(clean_q[0]) |=> WAKE_O)
    else $error("Enabled pin change gave no wake");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("Ack held too long");

endmodule // gwk_wake_irq
`default_nettype wire

// File: bench/gwk_pin_model.sv
// Purpose: Far-side pin drivers for the wake and interrupt block
// Assumes: Requested levels change just after a clock edge
// Notes: slow_i adds a one-cycle lag, like a slow edge on a long trace
`timescale 1ns/1ps
`default_nettype none
module gwk_pin_model (
  // Control
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [23:0] lvl_i,
  // Pins, bits 7:0 port A, 15:8 port B, 23:16 port C
  output logic [23:0] pin_o
);
  logic [23:0] lag_q;
  // ==========================================
  // Pins follow the request, late when asked
  always_ff @(posedge clk_i) begin
    lag_q <= lvl_i;
    pin_o <= slow_i ? lag_q : lvl_i;
  end
endmodule // gwk_pin_model
`default_nettype wire

// File: bench/tb_gwk_wake_irq.sv
// Purpose: Self-checking bench for the wake and interrupt block
// Assumes: Filter length 8, so a three-cycle pulse is too short for it
// Notes: Pin index equals the select code for every legal code
`include "gwk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_gwk_wake_irq;
  logic clk, rst, cyc, stb, we, ser_en, ack, wake, slow, wk;
  logic [31:0] adr, dat, dat_o, rd;
  logic [3:0] irq, irqs, sel;
  logic [23:0] lvl, pins;
  logic legal;
  int bad_count, checks_done, n;
  localparam logic [31:0] RA [12] = '{`GWK_ADR_FLAGS, `GWK_ADR_CFG_A, `GWK_ADR_CFG_B, `GWK_ADR_CFG_C,
    `GWK_ADR_CFG_D, `GWK_ADR_WAKE_A, `GWK_ADR_WAKE_B, `GWK_ADR_WAKE_C, `GWK_ADR_SEL_C, `GWK_ADR_SEL_D,
    `GWK_ADR_FILT, 32'h4000bc20};
  localparam logic [31:0] RV [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 32'h0f, 32'h10, 0, 0};
  localparam logic [31:0] RM [12] = '{0, 32'h1e0, 32'h1e0, 32'h1e0, 32'h1e0, 32'hff, 32'hff, 32'hff,
    32'h1f, 32'h1f, 32'h0b, 0};
  // Wake cases: pin, filter register, pulse length, wake expected
  localparam int WC [10][4] = '{'{19, 0, 12, 1}, '{18, 0, 12, 0}, '{19, 1, 3, 0}, '{19, 0, 3, 1},
    '{10, 2, 3, 0}, '{10, 0, 3, 1}, '{17, 8, 3, 0}, '{17, 0, 3, 1}, '{0, 0, 3, 1}, '{9, 0, 3, 0}};
  gwk_pin_model pm (.clk_i(clk), .slow_i(slow), .lvl_i(lvl), .pin_o(pins));
  gwk_wake_irq #(.FILT_LEN(8)) dut (.CLK_I(clk), .SYS_RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .PORT_A_I(pins[7:0]),
    .PORT_B_I(pins[15:8]), .PORT_C_I(pins[23:16]), .SERIAL_WAKE_EN_I(ser_en), .IRQ_O(irq), .WAKE_O(wake));
  // ==========================================
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Single verdict, also reached by a stuck bus
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // Classic cycle; holds everything until ack is seen
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        print_verdict();
      end
      @(posedge clk);
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(what, e, rd);
  endtask
  // Drive a pin, return it after len cycles, collect events for 30
  task automatic drive(input int idx, input logic v, input int len);
    irqs = 4'h0;
    wk = 1'b0;
    lvl[idx] <= v;
    for (int k = 0; k < 30; k++) begin
      @(posedge clk);
      if (k == len - 1) lvl[idx] <= ~v;
      irqs |= irq;
      wk |= wake;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {rst, cyc, stb, we, ser_en, slow} = 6'h20;
    {adr, dat, lvl} = '0;
    sel = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 12; i++) rchk("reset value", RA[i], RV[i]);
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, RA[i], 32'hffffffff);
      rchk("writable bits", RA[i], RM[i]);
      bus(1'b1, RA[i], 32'h0);
    end
    // Every trigger mode on channel C, pin C3
    bus(1'b1, `GWK_ADR_SEL_C, 32'h13);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, `GWK_ADR_CFG_C, m << 5);
      bus(1'b1, `GWK_ADR_FLAGS, 32'hd);
      drive(19, 1'b0, 99);
      cmp("low level", (8'h20 >> m) & 1, irqs[2]);
      bus(1'b1, `GWK_ADR_FLAGS, 32'hd);
      drive(19, 1'b1, 99);
      cmp("rising", (8'h3a >> m) & 1, irqs[2]);
      bus(1'b1, `GWK_ADR_FLAGS, 32'hd);
      drive(19, 1'b0, 99);
      cmp("falling", (8'h3c >> m) & 1, irqs[2]);
      rchk("flag C", `GWK_ADR_FLAGS, ((8'h3c >> m) & 1) << 2);
    end
    bus(1'b1, `GWK_ADR_CFG_C, 32'h0);
    // Select codes 0 to 24 on channel D, rising edge
    bus(1'b1, `GWK_ADR_CFG_D, 32'h20);
    for (int c = 0; c < 25; c++) begin
      legal = (c == 4) || (c == 5) || (c == 7) || (c >= 8 && c <= 12) || c >= 16;
      bus(1'b1, `GWK_ADR_SEL_D, c);
      drive(c, 1'b1, 99);
      cmp("select code", legal && c < 24, irqs[3]);
      lvl[c] <= 1'b0;
      bus(1'b1, `GWK_ADR_FLAGS, 32'hd);
      drive(c, 1'b0, 99);
      bus(1'b1, `GWK_ADR_FLAGS, 32'hd);
    end
    // Channel A: short pulse, clearing, filter
    bus(1'b1, `GWK_ADR_CFG_A, 32'h20);
    drive(8, 1'b1, 3);
    cmp("short pulse", 1, irqs[0]);
    rchk("flag A", `GWK_ADR_FLAGS, 32'h1);
    bus(1'b1, `GWK_ADR_FLAGS, 32'h0);
    rchk("zero write", `GWK_ADR_FLAGS, 32'h1);
    sel <= 4'h0;
    bus(1'b1, `GWK_ADR_FLAGS, 32'h1);
    sel <= 4'hf;
    rchk("lane off", `GWK_ADR_FLAGS, 32'h1);
    bus(1'b1, `GWK_ADR_FLAGS, 32'h1);
    rchk("one write", `GWK_ADR_FLAGS, 32'h0);
    bus(1'b1, `GWK_ADR_CFG_A, 32'h120);
    drive(8, 1'b1, 3);
    cmp("filtered pulse", 0, irqs[0]);
    slow <= 1'b1;
    drive(8, 1'b1, 12);
    cmp("filtered long", 1, irqs[0]);
    slow <= 1'b0;
    // Wake sources and their filters
    ser_en <= 1'b1;
    bus(1'b1, `GWK_ADR_WAKE_C, 32'h08);
    bus(1'b1, `GWK_ADR_WAKE_A, 32'h01);
    bus(1'b1, `GWK_ADR_SEL_D, 32'h11);
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, `GWK_ADR_FILT, WC[i][1]);
      drive(WC[i][0], 1'b1, WC[i][2]);
      cmp("wake", WC[i][3], wk);
    end
    // Serial pin may not wake once its enable input is low
    ser_en <= 1'b0;
    drive(10, 1'b1, 3);
    cmp("serial gated", 0, wk);
    print_verdict();
  end
endmodule // tb_gwk_wake_irq
`default_nettype wire
